/* File: src/spr_pkg.sv */
// constants shared by the single-port ram block
// assumes a single 100 MHz clock domain and synchronous user logic
//
// Operation
// - write strobe high stores data at address
// - strobe low: output shows addressed word
// - depth positive, all words one format
// - depth checked positive before build
// - initial entries beyond depth are dropped
// - words past initial list start zero
// - initial values saturated to data width
// - large ram clears to zero, no init
// - write-first shows newly written value
// - read-first shows old word value
// - no-change holds last non-write output
// - optional reset loads output register start value only; none on distributed
// - output reset only with latency one+
// - block ram output register initial value
// - large ram output register starts zero
// - distributed write-first needs latency, uses mux
package spr_pkg;
  typedef enum logic [1:0]
  {
    SPR_MEM_DIST = 2'h0,
    SPR_MEM_BLOCK = 2'h1,
    SPR_MEM_LARGE = 2'h2
  } spr_mem_t;

  typedef enum logic [1:0]
  {
    SPR_WR_FIRST = 2'h0,
    SPR_RD_FIRST = 2'h1,
    SPR_NO_CHANGE = 2'h2
  } spr_wmode_t;

  localparam int SPR_DEF_DEPTH = 16;
  localparam int SPR_DEF_WIDTH = 16;
  localparam int SPR_DEF_LATENCY = 1;
  localparam int SPR_MAX_INIT = 16;
  localparam logic [63:0] SPR_ZERO_WORD = 64'h0;
endpackage : spr_pkg

/* File: src/spr_sat.sv */
// saturates a signed 64-bit initial value into a narrower word
// assumes constant inputs; used for the initial words and the output-register start value
`timescale 1ns/1ps
`default_nettype none
module spr_sat #(
  parameter int WIDTH = 16,
  parameter bit SIGNED_FMT = 1'b0
) (
  input wire logic signed [63:0] value,
  output logic [WIDTH-1:0] sat
);
  localparam logic signed [63:0] UMAX = (64'sh1 <<< WIDTH) - 64'sh1;
  localparam logic signed [63:0] SMAX = (64'sh1 <<< (WIDTH - 1)) - 64'sh1;
  localparam logic signed [63:0] SMIN = -(64'sh1 <<< (WIDTH - 1));

  // clamp into the representable range of the data port
  always_comb
  begin
    if (SIGNED_FMT)
    begin
      if (value > SMAX) sat = SMAX[WIDTH-1:0];
      else if (value < SMIN) sat = SMIN[WIDTH-1:0];
      else sat = value[WIDTH-1:0];
    end
    else
    begin
      if (value < 64'sh0) sat = '0;
      else if (WIDTH < 63 && value > UMAX) sat = UMAX[WIDTH-1:0];
      else sat = value[WIDTH-1:0];
    end
  end
endmodule : spr_sat
`default_nettype wire

/* File: src/spr_delay.sv */
// pipeline stage holding the read word, with optional reset
// assumes latency stages are chained by the caller
`timescale 1ns/1ps
`default_nettype none
module spr_delay #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic out_rst,
  input wire logic [WIDTH-1:0] init_val,
  input wire logic load,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // reset only clears this stage, never the array behind it
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b) q <= '0;
    else if (ce)
    begin
      if (out_rst) q <= init_val;
      else if (load) q <= d;
    end
  end
endmodule : spr_delay
`default_nettype wire

/* File: src/spr_ram.sv */
// single-port ram: one address, one data in, one write strobe, one data out
// assumes the user side drives all inputs synchronously to sys_clk
`timescale 1ns/1ps
`default_nettype none
module spr_ram #(
  parameter int DEPTH = spr_pkg::SPR_DEF_DEPTH,
  parameter int WIDTH = spr_pkg::SPR_DEF_WIDTH,
  parameter int LATENCY = spr_pkg::SPR_DEF_LATENCY,
  parameter spr_pkg::spr_mem_t MEM_TYPE = spr_pkg::SPR_MEM_BLOCK,
  parameter spr_pkg::spr_wmode_t WRITE_MODE = spr_pkg::SPR_WR_FIRST,
  parameter bit SIGNED_FMT = 1'b0,
  parameter bit HAS_OUT_RST = 1'b0,
  parameter int INIT_LEN = 0,
  parameter logic signed [63:0] INIT_VEC [spr_pkg::SPR_MAX_INIT] = '{default: 64'sh0},
  parameter logic signed [63:0] OUT_INIT = 64'sh0,
  parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] din,
  input wire logic we,
  input wire logic out_rst,
  output logic [WIDTH-1:0] dout
);
  ////////////////////////////////////////////////////////////////////////////
  // build-time checks
  // a zero or negative depth cannot be built at all
  if (DEPTH < 1)
  begin : g_bad_depth
    $error("depth must be a positive integer");
  end
  // output reset needs a register to act on
  if (HAS_OUT_RST && LATENCY < 1)
  begin : g_bad_rst
    $error("output reset requires latency of at least one");
  end
  // distributed write-first forwards write data through a register stage
  if (MEM_TYPE == spr_pkg::SPR_MEM_DIST && WRITE_MODE == spr_pkg::SPR_WR_FIRST && LATENCY < 1)
  begin : g_bad_dist
    $error("distributed write-first requires latency above zero");
  end
  if (MEM_TYPE == spr_pkg::SPR_MEM_DIST && WRITE_MODE == spr_pkg::SPR_NO_CHANGE)
  begin : g_bad_nc
    $error("distributed memory supports read-first or write-first only");
  end

  localparam int USE_INIT = (MEM_TYPE == spr_pkg::SPR_MEM_LARGE) ? 0 : INIT_LEN;
  localparam int NINIT = (USE_INIT > DEPTH) ? DEPTH : USE_INIT;
  localparam int NINIT_C = (NINIT > spr_pkg::SPR_MAX_INIT) ? spr_pkg::SPR_MAX_INIT : NINIT;
  localparam logic signed [63:0] REG_INIT =
    (MEM_TYPE == spr_pkg::SPR_MEM_BLOCK) ? OUT_INIT : 64'sh0;
  localparam bit RST_EN = HAS_OUT_RST && (MEM_TYPE != spr_pkg::SPR_MEM_DIST)
    && (LATENCY >= 1);

  ////////////////////////////////////////////////////////////////////////////
  // saturated initial words and output-register start value
  logic [WIDTH-1:0] init_word [spr_pkg::SPR_MAX_INIT];
  logic [WIDTH-1:0] reg_init;

  for (genvar i = 0; i < spr_pkg::SPR_MAX_INIT; i++)
  begin : g_sat
    spr_sat #(.WIDTH(WIDTH), .SIGNED_FMT(SIGNED_FMT)) u_sat (
      .value(INIT_VEC[i]),
      .sat(init_word[i])
    );
  end

  spr_sat #(.WIDTH(WIDTH), .SIGNED_FMT(SIGNED_FMT)) u_sat_out (
    .value(REG_INIT),
    .sat(reg_init)
  );

  ////////////////////////////////////////////////////////////////////////////
  // storage array
  logic [WIDTH-1:0] mem [DEPTH];
  logic loaded;
  logic in_range;

  assign in_range = (32'(addr) < DEPTH);

  // contents are loaded once after reset; words past the list start at zero
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b) loaded <= 1'b0;
    else loaded <= 1'b1;
  end

  // trade-off: loading in one cycle after reset costs a wide mux but keeps
  // the array content defined without any file read
  always_ff @(posedge sys_clk)
  begin
    if (!loaded)
    begin
      for (int j = 0; j < DEPTH; j++)
      begin
        if (j < NINIT_C) mem[j] <= init_word[j];
        else mem[j] <= '0;
      end
    end
    else if (ce && we && in_range)
    begin
      mem[addr] <= din;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: what the port shows in the write cycle
  logic [WIDTH-1:0] old_word;
  logic [WIDTH-1:0] next_rd;
  logic rd_load;

  assign old_word = in_range ? mem[addr] : '0;

  // select per write mode; no-change simply does not load the stage
  always_comb
  begin
    next_rd = old_word;
    rd_load = 1'b1;
    if (we)
    begin
      unique case (WRITE_MODE)
        spr_pkg::SPR_WR_FIRST: next_rd = din;
        spr_pkg::SPR_RD_FIRST: next_rd = old_word;
        spr_pkg::SPR_NO_CHANGE: rd_load = 1'b0;
        default: next_rd = old_word;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latency pipeline
  logic [WIDTH-1:0] stage [LATENCY+1];
  logic [WIDTH-1:0] hold0;
  logic primed;

  // at zero latency no-change still needs a holding register
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b) hold0 <= '0;
    else if (ce && loaded && rd_load) hold0 <= next_rd;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b) primed <= 1'b0;
    else if (loaded) primed <= 1'b1;
  end

  assign stage[0] = (rd_load || LATENCY > 0) ? next_rd : hold0;

  for (genvar k = 0; k < LATENCY; k++)
  begin : g_pipe
    logic stage_rst;
    assign stage_rst = ((k == LATENCY - 1) && RST_EN && out_rst) || !primed;
    spr_delay #(.WIDTH(WIDTH)) u_stage (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .ce(ce),
      .out_rst(stage_rst),
      .init_val((k == LATENCY - 1) ? reg_init : '0),
      .load((k == 0) ? (rd_load && loaded) : 1'b1),
      .d(stage[k]),
      .q(stage[k+1])
    );
  end

  assign dout = stage[LATENCY];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [WIDTH-1:0] last_wdata;
  logic last_wr;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b) last_wr <= 1'b0;
    else last_wr <= ce && we && loaded && in_range;
  end
  always_ff @(posedge sys_clk)
  begin
    last_wdata <= din;
  end

  if (LATENCY == 1)
  begin : g_chk
    a_write_first_out: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (WRITE_MODE == spr_pkg::SPR_WR_FIRST && ce && we && loaded && primed && !out_rst)
      |=> dout == $past(din))
      else $error("write-first output not new data");
    a_read_first_out: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (WRITE_MODE == spr_pkg::SPR_RD_FIRST && ce && we && loaded && primed && !out_rst)
      |=> dout == $past(old_word))
      else $error("read-first output not old data");
    a_no_change_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (WRITE_MODE == spr_pkg::SPR_NO_CHANGE && we && primed && !out_rst)
      |=> $stable(dout))
      else $error("no-change output moved during write");
    a_read_word_out: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (ce && !we && loaded && primed && !out_rst) |=> dout == $past(old_word))
      else $error("read output not addressed word");
    a_write_stored: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (ce && we && loaded && in_range) |=> mem[$past(addr)] == $past(din))
      else $error("write not stored");
    a_out_reset_val: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (RST_EN && ce && out_rst) |=> dout == reg_init)
      else $error("output reset value wrong");
    a_out_reset_mem: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (out_rst && !we && loaded) |=> mem[$past(addr)] == $past(old_word))
      else $error("output reset disturbed memory");
    a_large_init_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (MEM_TYPE == spr_pkg::SPR_MEM_LARGE && !primed && loaded) |=> dout == '0)
      else $error("large ram output register not zero");
    a_stall_freeze: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!ce && primed) |=> $stable(dout))
      else $error("output moved with clock enable low");
    // the start value must reach the port once the array is loaded
    a_out_start_val: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (loaded && !primed && ce) |=> dout == reg_init)
      else $error("output register start value wrong");
    // distributed storage answers with the old word unless forwarding is on
    a_dist_old_word: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (MEM_TYPE == spr_pkg::SPR_MEM_DIST && WRITE_MODE != spr_pkg::SPR_WR_FIRST
      && ce && we && loaded && primed) |=> dout == $past(old_word))
      else $error("distributed write output not old data");
  end

  ////////////////////////////////////////////////////////////////////////////
  // contents checks, valid for any latency
  // the registered copy of the last write must be in the array one edge on
  a_write_landed: assert property (@(posedge sys_clk) disable iff (!rst_b)
    last_wr |-> mem[$past(addr)] == last_wdata)
    else $error("last write missing from array");
  // a stalled cycle must not touch the array, whatever the strobe says
  a_stall_no_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!ce && loaded && in_range) |=> mem[$past(addr)] == $past(old_word))
    else $error("array written with clock enable low");
  // the first loaded word is the saturated list head
  a_init_head: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (loaded && !primed && NINIT_C > 0) |-> mem[0] == init_word[0])
    else $error("first initial word wrong");
  // the top word lies past any short list and must start at zero
  a_init_tail_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (loaded && !primed && NINIT_C < DEPTH) |-> mem[DEPTH-1] == '0)
    else $error("word past initial list not zero");
  // large storage takes no user contents at all
  a_large_mem_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (MEM_TYPE == spr_pkg::SPR_MEM_LARGE && loaded && !primed) |-> mem[0] == '0)
    else $error("large ram not cleared at start");
endmodule : spr_ram
`default_nettype wire

/* File: tb/spr_user.sv */
// user-side logic that drives the ram port, one request per edge
// assumes the bench calls op at most once per clock cycle
`timescale 1ns/1ps
`default_nettype none
module spr_user (
  input wire logic sys_clk,
  output logic [3:0] addr,
  output logic [15:0] din,
  output logic we,
  output logic ce,
  output logic out_rst
);
  // idle read of word 0, so the port is never left floating
  initial
  begin
    addr = 4'h0;
    din = 16'h0000;
    we = 1'b0;
    ce = 1'b1;
    out_rst = 1'b0;
  end
  ////////////////////////////////////////
  // four address bits cannot leave a 16-word array
  task automatic op(input logic [3:0] a, input logic [15:0] d, input logic w, c, r);
    @(posedge sys_clk);
    addr <= a;
    din <= d;
    we <= w;
    ce <= c;
    out_rst <= r;
  endtask : op
endmodule : spr_user
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench: block write-first, large no-change, distributed read-first
// assumes 16 words of 16 bits and one cycle of read latency
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic signed [63:0] IV [spr_pkg::SPR_MAX_INIT] =
    '{0: 64'sh5, 1: 64'sh10000, default: 64'sh0};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr;
  logic [15:0] din;
  logic we;
  logic ce;
  logic out_rst;
  logic [15:0] dw;
  logic [15:0] dn;
  logic [15:0] ew;
  logic [15:0] en;
  logic [15:0] mw [16];
  logic [15:0] mn [16];
  logic [15:0] dr;
  logic [15:0] er;
  logic [15:0] mr [16];
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed_ret;
  ////////////////////////////////////////
  // all rams see the same requests
  spr_user user_i (.sys_clk(sys_clk), .addr(addr), .din(din), .we(we), .ce(ce),
    .out_rst(out_rst));
  spr_ram #(.WRITE_MODE(spr_pkg::SPR_WR_FIRST), .HAS_OUT_RST(1'b1), .INIT_LEN(2),
    .INIT_VEC(IV), .OUT_INIT(64'sh7)) spr_ram_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .ce(ce), .addr(addr), .din(din), .we(we), .out_rst(out_rst), .dout(dw));
  spr_ram #(.MEM_TYPE(spr_pkg::SPR_MEM_LARGE), .WRITE_MODE(spr_pkg::SPR_NO_CHANGE),
    .HAS_OUT_RST(1'b1), .INIT_LEN(2), .INIT_VEC(IV)) spr_ram_nc_i (.sys_clk(sys_clk),
    .rst_b(rst_b), .ce(ce), .addr(addr), .din(din), .we(we), .out_rst(out_rst),
    .dout(dn));
  // signed format saturates the second initial word to the positive limit
  spr_ram #(.MEM_TYPE(spr_pkg::SPR_MEM_DIST), .WRITE_MODE(spr_pkg::SPR_RD_FIRST),
    .SIGNED_FMT(1'b1), .INIT_LEN(2), .INIT_VEC(IV)) spr_ram_rf_i (.sys_clk(sys_clk),
    .rst_b(rst_b), .ce(ce), .addr(addr), .din(din), .we(we), .out_rst(out_rst),
    .dout(dr));
  // 100 MHz clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // hang guard, far above the ~230 cycles of the run
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      summarize();
    end
  end
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp)
      fail_count++;
  endtask : chk

  // drive one request, check the previous answer, then advance the model
  task automatic step(input logic [3:0] a, input logic [15:0] d, input logic w, c, r);
    user_i.op(a, d, w, c, r);
    #1;
    chk(dw, ew);
    chk(dn, en);
    chk(dr, er);
    if (c)
    begin
      er = mr[a];
      if (r)
        ew = 16'h0007;
      else if (w)
        ew = d;
      else
        ew = mw[a];
      if (r)
        en = 16'h0000;
      else if (!w)
        en = mn[a];
      if (w)
      begin
        mw[a] = d;
        mn[a] = d;
        mr[a] = d;
      end
    end
  endtask : step
  ////////////////////////////////////////
  // reset, init contents, output reset, then random traffic
  initial
  begin
    mw = '{default: 16'h0000};
    mn = '{default: 16'h0000};
    mw[0] = 16'h0005;
    mw[1] = 16'hFFFF;
    mr = '{default: 16'h0000};
    mr[0] = 16'h0005;
    mr[1] = 16'h7FFF;
    seed_ret = $urandom(32'h5B96F3DB);
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(dw, 16'h0007);
    chk(dn, 16'h0000);
    chk(dr, 16'h0000);
    ew = 16'h0005;
    er = 16'h0005;
    en = 16'h0000;
    $display("test reset done");
    for (int i = 0; i < 16; i++)
      step(i[3:0], 16'h0000, 1'b0, 1'b1, 1'b0);
    $display("test init done");
    step(4'h3, 16'hA5A5, 1'b1, 1'b1, 1'b0);
    step(4'h3, 16'h0000, 1'b0, 1'b1, 1'b1);
    step(4'h3, 16'h0000, 1'b0, 1'b1, 1'b0);
    $display("test output reset done");
    // stalls and output resets land mid-stream
    for (int i = 0; i < 200; i++)
      step(4'($urandom), 16'($urandom), 1'($urandom), 3'($urandom) != 3'h0,
        4'($urandom) == 4'h0);
    step(4'h0, 16'h0000, 1'b0, 1'b1, 1'b0);
    $display("test random done");
    summarize();
  end
endmodule : tb
`default_nettype wire
